// *** adcc_regs.svh ***
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// register indices; byte address is four times the index
`define ADCC_IDX_CTRL 6'h14
`define ADCC_IDX_CFG 6'h15
`define ADCC_IDX_RESH 6'h16
`define ADCC_IDX_RESL 6'h17
`define ADCC_IDX_IRQ 6'h18

// control register fields
`define ADCC_CTRL_EN 0
`define ADCC_CTRL_GO 2
`define ADCC_CTRL_CHS 4
`define ADCC_CTRL_RST 8'h00

// configuration register fields
`define ADCC_CFG_REF 0
`define ADCC_CFG_PCFG 1
`define ADCC_CFG_FM 5
`define ADCC_CFG_CS 6
`define ADCC_CFG_RST 8'h00

// interrupt register fields
`define ADCC_IRQ_FLAG 0
`define ADCC_IRQ_EN 1

// timing
`define ADCC_CLK_MHZ 25
`define ADCC_DIV8 7'h08
`define ADCC_DIV32 7'h20
`define ADCC_DIV64 7'h40
`define ADCC_RC_PERIOD_NS 2000
`define ADCC_RC_PERIOD_CYC (`ADCC_RC_PERIOD_NS * `ADCC_CLK_MHZ / 1000)
`define ADCC_CONV_PERIODS 4'hc
`define ADCC_GAP_PERIODS 4'h2

`endif

// *** adcc_pkg.sv ***
package adcc_pkg;
	typedef enum logic [1:0] {
		ADCC_ST_OFF = 2'b00,
		ADCC_ST_ACQ = 2'b01,
		ADCC_ST_CONV = 2'b10,
		ADCC_ST_GAP = 2'b11
	} adcc_state_t;

	typedef enum logic [1:0] {
		ADCC_CK_DIV8 = 2'b00,
		ADCC_CK_DIV32 = 2'b01,
		ADCC_CK_DIV64 = 2'b10,
		ADCC_CK_RC = 2'b11
	} adcc_clksel_t;
endpackage

// *** adcc_conv_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface adcc_conv_if;
	import adcc_pkg::*;
	logic run;
	logic start;
	logic cmp;
	adcc_clksel_t sel;
	logic tick;
	logic busy;
	logic done;
	logic sample_en;
	logic [9:0] result;
	logic [9:0] trial;

	modport ctrl (output run, start, cmp, sel, input tick, busy, done, sample_en, result, trial);
	modport tadgen (input run, start, sel, output tick);
	modport sar (input run, start, cmp, tick, output busy, done, sample_en, result, trial);
endinterface
`default_nettype wire

// *** adcc_tad_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"
module adcc_period_gen
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter side
	adcc_conv_if.tadgen cif
);
	logic [6:0] period;
	logic [6:0] cnt_q;

	always_comb begin
		case (cif.sel)
			ADCC_CK_DIV8: period = `ADCC_DIV8;
			ADCC_CK_DIV32: period = `ADCC_DIV32;
			ADCC_CK_DIV64: period = `ADCC_DIV64;
			ADCC_CK_RC: period = 7'(`ADCC_RC_PERIOD_CYC);
			default: period = `ADCC_DIV8;
		endcase
	end

	// restart on start so the first period is whole; idle when powered down
	always_ff @(posedge aclk) begin
		if (!aresetn || !cif.run || cif.start) begin
			cnt_q <= 7'h00;
			cif.tick <= 1'b0;
		end else if (cnt_q == period - 7'h01) begin
			cnt_q <= 7'h00;
			cif.tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 7'h01;
			cif.tick <= 1'b0;
		end
	end

	chk_period_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		cif.tick |=> !cif.tick [*7]) else $error("conversion period shorter than eight clocks");
endmodule
`default_nettype wire

// *** adcc_sar.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"
module adcc_sar
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter side
	adcc_conv_if.sar cif
);
	adcc_state_t state_q;
	logic [3:0] cnt_q;
	logic [9:0] trial_q;
	logic [9:0] nxt_trial;
	logic [10:0] cur_w;
	logic [9:0] cur;
	logic [3:0] ticks_q;

	// one bit decided per period, msb first
	always_comb begin
		cur_w = 11'h400 >> cnt_q;
		cur = cur_w[9:0];
		nxt_trial = (cif.cmp ? trial_q : (trial_q & ~cur)) | (cur >> 1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ADCC_ST_OFF;
			cnt_q <= 4'h0;
			cif.done <= 1'b0;
		end else begin
			cif.done <= 1'b0;
			if (!cif.run) begin
				state_q <= ADCC_ST_OFF;
				cnt_q <= 4'h0;
			end else begin
				case (state_q)
					ADCC_ST_OFF: state_q <= ADCC_ST_ACQ;
					ADCC_ST_ACQ: begin
						if (cif.start) begin
							state_q <= ADCC_ST_CONV;
							cnt_q <= 4'h0;
						end
					end
					ADCC_ST_CONV: begin
						if (cif.tick && cnt_q == `ADCC_CONV_PERIODS - 4'h1) begin
							state_q <= ADCC_ST_GAP;
							cnt_q <= 4'h0;
							cif.done <= 1'b1;
						end else if (cif.tick) begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
					ADCC_ST_GAP: begin
						if (cif.tick && cnt_q == `ADCC_GAP_PERIODS - 4'h1) begin
							state_q <= ADCC_ST_ACQ;
							cnt_q <= 4'h0;
						end else if (cif.tick) begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
					default: state_q <= ADCC_ST_OFF;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trial_q <= 10'h000;
			cif.result <= 10'h000;
		end else if (state_q == ADCC_ST_CONV && cif.tick) begin
			if (cnt_q == 4'h0) begin
				trial_q <= 10'h200;
			end else if (cnt_q <= 4'ha) begin
				trial_q <= nxt_trial;
			end else begin
				cif.result <= trial_q;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cif.sample_en <= 1'b0;
		end else begin
			cif.sample_en <= cif.run && state_q == ADCC_ST_ACQ && !cif.start;
		end
	end

	assign cif.busy = (state_q == ADCC_ST_CONV);
	assign cif.trial = trial_q;

	// helper: periods seen since start
	always_ff @(posedge aclk) begin
		if (!aresetn || cif.start) begin
			ticks_q <= 4'h0;
		end else if (state_q == ADCC_ST_CONV && cif.tick) begin
			ticks_q <= ticks_q + 4'h1;
		end
	end

	sequence gap_closed_s;
		!cif.sample_en [*8];
	endsequence

	chk_conv_twelve_tad: assert property (@(posedge aclk) disable iff (!aresetn)
		cif.done |-> ticks_q == 4'hc) else $error("conversion did not last twelve periods");
	chk_gap_disconnect: assert property (@(posedge aclk) disable iff (!aresetn)
		cif.done |-> gap_closed_s) else $error("capacitor reconnected during gap");
endmodule
`default_nettype wire

// *** adcc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"
module adcc_top
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// analog front end
	input wire logic cmp_in,
	output logic converter_power,
	output logic ref_ext_sel,
	output logic [3:0] channel_sel,
	output logic [15:0] analog_map,
	output logic sample_connect,
	output logic [9:0] dac_code,
	// interrupt request
	output logic conv_irq_req
);
	adcc_conv_if cif ();

	logic [7:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb_q;
	logic we;
	logic [5:0] w_idx;
	logic [5:0] r_idx;
	logic [5:0] rd_idx_q;
	logic [7:0] rd_d;
	logic rd_ok;
	logic en_q;
	logic go_q;
	logic [3:0] chs_q;
	logic [7:0] cfg_q;
	logic flag_q;
	logic ien_q;
	logic start_q;
	logic cmp_s1_q;
	logic cmp_s2_q;
	logic [15:0] map_d;
	logic [2:0] pcfg;

	assign w_idx = aw_addr_q[7:2];
	assign r_idx = araddr[7:2];
	assign we = !awready && !wready && !bvalid;
	assign pcfg = cfg_q[`ADCC_CFG_PCFG +: 3];

	////////////////////////////////////////////////////////////////////////
	// bus slave

	// address and data taken in either order, held until both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_addr_q <= 8'h00;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data_q <= wdata[7:0];
				w_strb_q <= wstrb[0];
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else if (we) begin
			bvalid <= 1'b1;
			bresp <= (w_idx >= `ADCC_IDX_CTRL && w_idx <= `ADCC_IDX_IRQ) ? 2'b00 : 2'b10;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read mux; justification applied at read time
	always_comb begin
		rd_ok = 1'b1;
		case (r_idx)
			`ADCC_IDX_CTRL: rd_d = {chs_q, 1'b0, go_q, 1'b0, en_q};
			`ADCC_IDX_CFG: rd_d = {cfg_q[7:5], 1'b0, cfg_q[3:0]};
			`ADCC_IDX_RESH: rd_d = cfg_q[`ADCC_CFG_FM] ? {6'h00, cif.result[9:8]} : cif.result[9:2];
			`ADCC_IDX_RESL: rd_d = cfg_q[`ADCC_CFG_FM] ? cif.result[7:0] : {cif.result[1:0], 6'h00};
			`ADCC_IDX_IRQ: rd_d = {6'h00, ien_q, flag_q};
			default: begin
				rd_d = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'b00;
			rd_idx_q <= 6'h00;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, rd_d};
			rresp <= rd_ok ? 2'b00 : 2'b10;
			rd_idx_q <= r_idx;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q <= 1'(`ADCC_CTRL_RST);
			chs_q <= 4'h0;
		end else if (we && w_strb_q && w_idx == `ADCC_IDX_CTRL) begin
			en_q <= w_data_q[`ADCC_CTRL_EN];
			chs_q <= w_data_q[`ADCC_CTRL_CHS +: 4];
		end
	end

	// configuration: clock select, format, port map, reference
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= `ADCC_CFG_RST;
		end else if (we && w_strb_q && w_idx == `ADCC_IDX_CFG) begin
			cfg_q <= {w_data_q[7:5], 1'b0, w_data_q[3:0]};
		end
	end

	// start only when already powered and acquiring
	// a start written together with the enable is ignored, which also keeps
	// a conversion from running before the reference has settled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_q <= 1'b0;
			go_q <= 1'b0;
		end else begin
			start_q <= we && w_strb_q && w_idx == `ADCC_IDX_CTRL && w_data_q[`ADCC_CTRL_GO]
				&& en_q && !go_q && cif.sample_en;
			if (!en_q) begin
				go_q <= 1'b0;
			end else if (cif.done) begin
				go_q <= 1'b0;
			end else if (start_q) begin
				go_q <= 1'b1;
			end
		end
	end

	// sticky flag, hardware set beats software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
			ien_q <= 1'b0;
		end else begin
			if (we && w_strb_q && w_idx == `ADCC_IDX_IRQ) begin
				ien_q <= w_data_q[`ADCC_IRQ_EN];
				flag_q <= w_data_q[`ADCC_IRQ_FLAG];
			end
			if (cif.done) begin
				flag_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog side

	// comparator arrives asynchronously; two stages before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			cmp_s1_q <= cmp_in;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	// top inputs of each group go digital
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_map
			assign map_d[gi] = !(pcfg == 3'h7 || (pcfg != 3'h0 && 4'(gi % 8) >= 4'h8 - {1'b0, pcfg}));
		end
	endgenerate

	// registered pin controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_map <= 16'hffff;
			ref_ext_sel <= 1'b0;
			converter_power <= 1'b0;
			channel_sel <= 4'h0;
			conv_irq_req <= 1'b0;
		end else begin
			analog_map <= map_d;
			ref_ext_sel <= cfg_q[`ADCC_CFG_REF];
			converter_power <= en_q;
			channel_sel <= chs_q;
			conv_irq_req <= flag_q && ien_q;
		end
	end

	assign cif.run = en_q;
	assign cif.start = start_q;
	assign cif.cmp = cmp_s2_q;
	assign cif.sel = adcc_clksel_t'(cfg_q[`ADCC_CFG_CS +: 2]);
	assign sample_connect = cif.sample_en;
	assign dac_code = cif.trial;

	adcc_period_gen u_period (
		.aclk(aclk),
		.aresetn(aresetn),
		.cif(cif.tadgen)
	);

	adcc_sar u_sar (
		.aclk(aclk),
		.aresetn(aresetn),
		.cif(cif.sar)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence done_s;
		cif.done;
	endsequence

	chk_power_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		!en_q |=> !sample_connect && !converter_power) else $error("converter active while disabled");
	chk_done_clears_go: assert property (@(posedge aclk) disable iff (!aresetn)
		done_s |=> !go_q && flag_q) else $error("completion did not clear start or set flag");
	chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		flag_q && !(we && w_idx == `ADCC_IDX_IRQ) |=> flag_q) else $error("flag dropped without clear");
	chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 conv_irq_req |-> $past(flag_q) && $past(ien_q)) else $error("request without enabled flag");
	chk_ctrl_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid && rd_idx_q == `ADCC_IDX_CTRL |-> rdata[3] == 1'b0 && rdata[1] == 1'b0)
		else $error("reserved control bit read nonzero");
	chk_right_just: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(rvalid) && rd_idx_q == `ADCC_IDX_RESH && cfg_q[`ADCC_CFG_FM] |-> rdata[7:2] == 6'h00)
		else $error("right justified high byte not zero padded");
	chk_left_just: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(rvalid) && rd_idx_q == `ADCC_IDX_RESL && !cfg_q[`ADCC_CFG_FM] |-> rdata[5:0] == 6'h00)
		else $error("left justified low byte not zero padded");
	chk_map_extremes: assert property (@(posedge aclk) disable iff (!aresetn)
		(pcfg == 3'h0 |=> analog_map == 16'hffff) and (pcfg == 3'h7 |=> analog_map == 16'h0000))
		else $error("port map extremes wrong");
	// an accepted start must put the converter to work on the next edge
	chk_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		start_q && en_q |=> cif.busy) else $error("start did not begin a conversion");
endmodule
`default_nettype wire

// *** adc_conversion_control_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"
module adc_conversion_control_bench;
	// clock, reset and bus
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cmp_in;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [2:0] awprot, arprot;
	logic [1:0] bresp, rresp;
	// analog front end and interrupt
	logic converter_power, ref_ext_sel, sample_connect, conv_irq_req;
	logic [3:0] channel_sel;
	logic [15:0] analog_map;
	logic [9:0] dac_code, vin;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	localparam logic [7:0] a_ctrl = {`ADCC_IDX_CTRL, 2'b00};
	localparam logic [7:0] a_cfg = {`ADCC_IDX_CFG, 2'b00};
	localparam logic [7:0] a_resh = {`ADCC_IDX_RESH, 2'b00};
	localparam logic [7:0] a_resl = {`ADCC_IDX_RESL, 2'b00};
	localparam logic [7:0] a_irq = {`ADCC_IDX_IRQ, 2'b00};

	adcc_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .cmp_in(cmp_in),
		.converter_power(converter_power), .ref_ext_sel(ref_ext_sel), .channel_sel(channel_sel),
		.analog_map(analog_map), .sample_connect(sample_connect), .dac_code(dac_code),
		.conv_irq_req(conv_irq_req));

	////////////////////////////////////////////////////////////////
	// clock, comparator and hang guard
	always #20 aclk = ~aclk;
	// comparator answers one cycle late, like a slow analog path would
	always @(posedge aclk) begin
		cmp_in <= (dac_code <= vin);
	end
	// longest run is four conversions plus setup, far below this ceiling
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////
	// compare, report and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf,
		input logic [1:0] er = 2'b00);
		logic aw_p = 1'b1;
		logic w_p = 1'b1;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {24'h00_0000, d};
		wstrb <= s;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (aw_p && awready === 1'b1) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready === 1'b1) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				chk(32'(bresp), 32'(er));
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] mb, hi, lo;
		logic fm, ie;
		int per [4] = '{8, 32, 64, `ADCC_RC_PERIOD_CYC};
		logic [9:0] vins [4] = '{10'h2b5, 10'h3ff, 10'h001, 10'h156};
		int t0, el;
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb, awprot, arprot, vin} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset state
		chk(32'(converter_power), 32'h0000_0000); // powered off
		rdc(a_ctrl, 32'h0000_0000); // control resets zero
		rdc(a_cfg, 32'h0000_0000); // config resets zero
		chk(32'(analog_map), 32'h0000_ffff); // all analog
		// unmapped and masked accesses
		rdc(8'h7c, 32'h0000_0000, 2'b10);
		wr(8'h7c, 8'hff, 4'hf, 2'b10);
		wr(a_cfg, 8'hff); // bit four stays zero
		rdc(a_cfg, 32'h0000_00ef); // unimplemented bit reads zero
		wr(a_cfg, 8'h00, 4'h0);
		rdc(a_cfg, 32'h0000_00ef);
		wr(a_ctrl, 8'hfa);
		rdc(a_ctrl, 32'h0000_00f0); // bits three and one zero
		chk(32'(channel_sel), 32'h0000_000f); // channel code
		// every port map code, reference bit alternating
		for (int k = 0; k < 8; k++) begin
			wr(a_cfg, {4'h0, k[2:0], k[0]});
			mb = (k == 7) ? 8'h00 : 8'hff >> k;
			repeat (2) @(posedge aclk);
			chk(32'(analog_map), {16'h0000, mb, mb}); // analog map
			chk(32'(ref_ext_sel), 32'(k[0])); // reference select
		end
		// start in the enabling write is ignored
		wr(a_ctrl, 8'h05);
		rdc(a_ctrl, 32'h0000_0001); // start refused
		wr(a_ctrl, 8'h31);
		repeat (3) @(posedge aclk);
		chk(32'(converter_power), 32'h0000_0001); // powered on
		chk(32'(channel_sel), 32'h0000_0003); // channel three
		// one conversion per clock select code
		for (int cs = 0; cs < 4; cs++) begin
			vin = vins[cs];
			fm = ~cs[0];
			ie = cs[0];
			wr(a_cfg, {cs[1:0], fm, 5'h00}); // inputs analog, rails reference
			wr(a_irq, {6'h00, ie, 1'b0}); // flag cleared, enable chosen
			while (sample_connect !== 1'b1) @(posedge aclk); // acquire before start
			wr(a_ctrl, 8'h35);
			t0 = cyc;
			rdc(a_ctrl, 32'h0000_0035); // start bit reads set
			do rd(a_ctrl, d, r); while (d[2] === 1'b1); // poll start bit
			el = cyc - t0;
			chk(32'(el >= 12 * per[cs] - 4 && el <= 12 * per[cs] + 8), 32'h0000_0001);
			chk(32'(sample_connect), 32'h0000_0000); // capacitor off in gap
			chk(d, 32'h0000_0031); // start cleared by hardware
			chk(32'(dac_code), 32'(vin)); // final trial equals input
			chk(32'(conv_irq_req), 32'(ie)); // request gated by enable
			hi = fm ? {6'h00, vin[9:8]} : vin[9:2];
			lo = fm ? vin[7:0] : {vin[1:0], 6'h00};
			rdc(a_resh, {24'h00_0000, hi});
			rdc(a_resl, {24'h00_0000, lo});
			rdc(a_irq, {30'h0000_0000, ie, 1'b1}); // flag set and held
			wr(a_irq, {6'h00, ie, 1'b0}); // software clears flag
			rdc(a_irq, {30'h0000_0000, ie, 1'b0}); // cleared by software
			repeat (2) @(posedge aclk);
			chk(32'(conv_irq_req), 32'h0000_0000); // request drops
		end
		// last gap is two RC periods; acquiring must be back by then
		repeat (2 * per[3] + 8) @(posedge aclk);
		chk(32'(sample_connect), 32'h0000_0001); // acquiring again
		// shut off
		wr(a_ctrl, 8'h00);
		repeat (3) @(posedge aclk);
		chk(32'(converter_power), 32'h0000_0000); // powered off
		conclude();
	end
endmodule
`default_nettype wire
